// ### design/feeder_pkg.sv
// Shared constants and carrier types for the feeder transport supervisor
package feeder_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ          = 200_000_000;
  // Millisecond tick divisor, derived from the clock rate
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned MS_CNT_W        = 18;

  // Time limits in milliseconds
  localparam logic [15:0] ENTRY_WAIT_MS   = 16'h01F4; // 500 ms
  localparam logic [15:0] REG_CLEAR_MS    = 16'h012C; // 300 ms

  // Travel limits in millimetres
  localparam logic [15:0] ENTRY_TAIL_MM   = 16'h01BA; // 442 mm
  localparam logic [15:0] REG_TAIL_MM     = 16'h02EF; // 751 mm
  localparam logic [15:0] EXIT_REACH_MM   = 16'h0081; // 129 mm
  localparam logic [15:0] INV_EXIT_MM     = 16'h00C6; // 198 mm
  localparam logic [15:0] INV_REACH_MM    = 16'h0060; // 96 mm
  localparam logic [15:0] INV_BACK_MM     = 16'h0060; // 96 mm

  // Exit dwell factor 1.3 as 13/10
  localparam logic [3:0]  DWELL_NUM       = 4'hD;
  localparam logic [3:0]  DWELL_DEN       = 4'hA;

  // Encoder pulses per millimetre of travel, default value
  localparam logic [7:0]  PULSES_PER_MM   = 8'h04;
  // Delay after inverter sensor release before slow-down, in mm
  localparam logic [15:0] SLOW_DELAY_MM   = 16'h000A;

  // Jam identifiers, one bit per condition
  localparam int unsigned JAM_W           = 10;
  localparam int unsigned J_ENTRY_LATE    = 0;
  localparam int unsigned J_REG_STUCK     = 1;
  localparam int unsigned J_ENTRY_TAIL    = 2;
  localparam int unsigned J_REG_TAIL      = 3;
  localparam int unsigned J_EXIT_LATE     = 4;
  localparam int unsigned J_EXIT_DWELL    = 5;
  localparam int unsigned J_INV_EXIT_LATE = 6;
  localparam int unsigned J_INV_DWELL     = 7;
  localparam int unsigned J_INV_REACH     = 8;
  localparam int unsigned J_INV_BACK      = 9;

  // Transport phases, one-hot
  typedef enum logic [4:0] {
    PH_IDLE  = 5'h01,
    PH_FEED  = 5'h02,
    PH_OUT   = 5'h04,
    PH_INV   = 5'h08,
    PH_JAM   = 5'h10
  } phase_t;

  // Sensor levels, used both raw and after synchronisation
  typedef struct packed {
    logic entrance;
    logic registration;
    logic exit_s;
    logic inverter;
    logic encoder;
  } sensors_t;

  // Actuator drive levels
  typedef struct packed {
    logic feed_motor;
    logic feed_fast;
    logic belt_motor;
    logic out_motor;
    logic out_slow;
    logic exit_gate;
    logic inv_gate;
  } drive_t;

  // Commands from the copier controller, one-cycle pulses
  typedef struct packed {
    logic feed_in;
    logic speed_up;
    logic feed_out;
    logic invert;
    logic duplex;
    logic clear;
  } cmd_t;

endpackage

// ### design/feeder_jam_monitor.sv
// Feeder transport supervisor: gate drive, exit motor control, jam detection
`timescale 1ns/1ps

// How it works
// RULE1 - Duplex exit: exit gate on, inverter gate off
// RULE2 - Duplex exit: belt off after exit tail
// RULE3 - Duplex exit: slow out motor after inverter tail
// RULE4 - Entrance not on 500 ms after feed
// RULE5 - Registration not off 300 ms after speedup
// RULE6 - Entrance still on 442 mm past registration
// RULE7 - Registration still on 751 mm past on
// RULE8 - Exit still off 129 mm after feed-out
// RULE9 - Exit on beyond 1.3 times length
// RULE10 - Exit still off 198 mm into inversion
// RULE11 - Inverter off 96 mm past exit on
// RULE12 - Inverter off 96 mm past exit off
// RULE13 - Length counted registration on to entrance off
// RULE14 - Simplex exit keeps exit gate closed
// RULE15 - Distance by encoder, time by ms tick
// RULE16 - Jam latches flag, stops all drives
module feeder_jam_monitor
  import feeder_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire sensors_t         sensors_raw,
  input  wire cmd_t             cmd,
  output logic [7:0]            pulses_per_mm_unused,
  output drive_t                drive,
  output logic [JAM_W-1:0]      jam_flags,
  output logic                  jam,
  output logic [15:0]           orig_len_mm
);

  // Whole module state
  // One struct so the whole block resets and registers together
  // Counters are 16 bits, ample for the longest travel limit
  typedef struct packed {
    sensors_t           s1;        // First sync stage
    sensors_t           s2;        // Second sync stage
    sensors_t           prev;      // Last sampled levels, edge detect
    phase_t             phase;
    logic               duplex;    // Latched double-sided mode
    logic [MS_CNT_W-1:0] ms_div;   // Millisecond divider
    logic [7:0]         mm_div;    // Encoder pulses within a mm
    logic [15:0]        t_entry;   // ms since feed motor on
    logic               t_entry_on;
    logic [15:0]        t_reg;     // ms since speed-up
    logic               t_reg_on;
    logic [15:0]        d_reg;     // mm since registration on
    logic               d_reg_on;
    logic [15:0]        d_out;     // mm since feed-out or invert start
    logic               d_out_on;
    logic [15:0]        d_exit;    // mm since exit sensor on
    logic               d_exit_on;
    logic [15:0]        d_exoff;   // mm since exit sensor off
    logic               d_exoff_on;
    logic [15:0]        d_slow;    // mm since inverter sensor off
    logic               d_slow_on;
    logic [15:0]        len;       // Measured original length, mm
    logic               len_on;
    logic [19:0]        dwell;     // Exit dwell limit, mm
    drive_t             drv;
    logic [JAM_W-1:0]   flags;
  } state_t;

  state_t st_reg;   // Registered state
  state_t st_next;  // Next state

  // Edge and tick helpers
  // Combinational only, recomputed from registered state
  // Edges compare the second sync stage with its previous sample in prev
  // hit carries one bit per jam condition
  logic ms_tick;
  logic mm_tick;
  logic enc_rise;
  logic reg_rise;
  logic ent_fall;
  logic exit_rise;
  logic exit_fall;
  logic inv_fall;
  logic [JAM_W-1:0] hit;

  // Next-state logic
  // Default holds every field; branches below override it
  // Later assignments win, so the jam block sits last and
  // overrides any command taken in the same cycle
  always_comb begin
    st_next = st_reg;
    // Sensors cross from pins through two flops before use
    // Only the second stage feeds logic, never the first
    st_next.s1   = sensors_raw;
    st_next.s2   = st_reg.s1;
    st_next.prev = st_reg.s2;

    // Time base and distance base
    // Divider free-runs, so a window's first ms may be short
    // Encoder edges are counted; one mm is several pulses
    ms_tick   = (st_reg.ms_div == MS_CNT_W'(MS_CYCLES - 1)); // RULE15
    st_next.ms_div = ms_tick ? '0 : st_reg.ms_div + 1'b1;
    enc_rise  = st_reg.s2.encoder & ~st_reg.prev.encoder;
    mm_tick   = enc_rise && (st_reg.mm_div == PULSES_PER_MM - 8'h01); // RULE15
    if (enc_rise) begin
      st_next.mm_div = mm_tick ? '0 : st_reg.mm_div + 8'h01;
    end

    // Edge strobes, one cycle wide each
    reg_rise  = st_reg.s2.registration & ~st_reg.prev.registration;
    ent_fall  = ~st_reg.s2.entrance & st_reg.prev.entrance;
    exit_rise = st_reg.s2.exit_s & ~st_reg.prev.exit_s;
    exit_fall = ~st_reg.s2.exit_s & st_reg.prev.exit_s;
    inv_fall  = ~st_reg.s2.inverter & st_reg.prev.inverter;

    // Running counters saturate rather than wrap
    // A wrapped counter would drop back under its limit
    // and hide a jam that is already overdue
    if (st_reg.t_entry_on && ms_tick && ~&st_reg.t_entry)
      st_next.t_entry = st_reg.t_entry + 16'h0001;
    if (st_reg.t_reg_on && ms_tick && ~&st_reg.t_reg)
      st_next.t_reg = st_reg.t_reg + 16'h0001;
    if (st_reg.d_reg_on && mm_tick && ~&st_reg.d_reg)
      st_next.d_reg = st_reg.d_reg + 16'h0001;
    if (st_reg.d_out_on && mm_tick && ~&st_reg.d_out)
      st_next.d_out = st_reg.d_out + 16'h0001;
    if (st_reg.d_exit_on && mm_tick && ~&st_reg.d_exit)
      st_next.d_exit = st_reg.d_exit + 16'h0001;
    if (st_reg.d_exoff_on && mm_tick && ~&st_reg.d_exoff)
      st_next.d_exoff = st_reg.d_exoff + 16'h0001;
    if (st_reg.d_slow_on && mm_tick && ~&st_reg.d_slow)
      st_next.d_slow = st_reg.d_slow + 16'h0001;
    if (st_reg.len_on && mm_tick && ~&st_reg.len)
      st_next.len = st_reg.len + 16'h0001;

    // Length runs from registration on to entrance off
    // The same edge opens both registration distance windows
    if (reg_rise) begin
      st_next.len_on = 1'b1; // RULE13
      st_next.len    = '0;
      st_next.d_reg_on = 1'b1;
      st_next.d_reg    = '0;
    end
    if (ent_fall && st_reg.len_on) begin
      st_next.len_on = 1'b0; // RULE13
    end
    // Dwell limit: length times 13/10, truncated, every cycle
    // Follows len, so it is final once the tail clears entrance
    st_next.dwell = 20'((st_reg.len * DWELL_NUM) / DWELL_DEN); // RULE9

    // Exit sensor edges start the downstream distance windows
    // Exit rise ends the reach window, starts the dwell window
    if (exit_rise) begin
      st_next.d_exit_on = 1'b1;
      st_next.d_exit    = '0;
      st_next.d_out_on  = 1'b0;
    end
    // Exit fall starts the return window only in inversion
    if (exit_fall) begin
      st_next.d_exit_on  = 1'b0;
      st_next.d_exoff_on = (st_reg.phase == PH_INV);
      st_next.d_exoff    = '0;
      // Duplex exit: belt stops once the tail clears
      if (st_reg.phase == PH_OUT && st_reg.duplex)
        st_next.drv.belt_motor = 1'b0; // RULE2
    end
    // Inverter release in duplex exit arms the slow-down delay
    if (inv_fall && st_reg.phase == PH_OUT && st_reg.duplex) begin
      st_next.d_slow_on = 1'b1;
      st_next.d_slow    = '0;
    end
    // Short travel after inverter release, then slow down
    if (st_reg.d_slow_on && st_reg.d_slow >= SLOW_DELAY_MM) begin
      st_next.drv.out_slow = 1'b1; // RULE3
      st_next.d_slow_on    = 1'b0;
    end
    // Stop checking entrance once it reports
    // Time windows close as soon as their sensor answers
    if (st_reg.s2.entrance) st_next.t_entry_on = 1'b0;
    if (!st_reg.s2.registration) st_next.t_reg_on = 1'b0;
    if (st_reg.s2.inverter) st_next.d_exoff_on = 1'b0;

    // Jam conditions, each tied to a window, some windows shared
    // Distance limits use >= so a jam lands on the limit mm
    // Dwell uses > since a sheet may sit exactly that long
    hit = '0;
    hit[J_ENTRY_LATE] = st_reg.t_entry_on && !st_reg.s2.entrance &&
                        st_reg.t_entry >= ENTRY_WAIT_MS; // RULE4
    hit[J_REG_STUCK]  = st_reg.t_reg_on && st_reg.s2.registration &&
                        st_reg.t_reg >= REG_CLEAR_MS; // RULE5
    hit[J_ENTRY_TAIL] = st_reg.d_reg_on && st_reg.s2.entrance &&
                        st_reg.d_reg >= ENTRY_TAIL_MM; // RULE6
    hit[J_REG_TAIL]   = st_reg.d_reg_on && st_reg.s2.registration &&
                        st_reg.d_reg >= REG_TAIL_MM; // RULE7
    hit[J_EXIT_LATE]  = st_reg.phase == PH_OUT && st_reg.d_out_on &&
                        !st_reg.s2.exit_s &&
                        st_reg.d_out >= EXIT_REACH_MM; // RULE8
    hit[J_EXIT_DWELL] = st_reg.phase == PH_OUT && st_reg.d_exit_on &&
                        st_reg.s2.exit_s &&
                        20'(st_reg.d_exit) > st_reg.dwell; // RULE9
    hit[J_INV_EXIT_LATE] = st_reg.phase == PH_INV && st_reg.d_out_on &&
                           !st_reg.s2.exit_s &&
                           st_reg.d_out >= INV_EXIT_MM; // RULE10
    hit[J_INV_DWELL]  = st_reg.phase == PH_INV && st_reg.d_exit_on &&
                        st_reg.s2.exit_s &&
                        20'(st_reg.d_exit) > st_reg.dwell; // RULE9
    hit[J_INV_REACH]  = st_reg.phase == PH_INV && st_reg.d_exit_on &&
                        !st_reg.s2.inverter &&
                        st_reg.d_exit >= INV_REACH_MM; // RULE11
    hit[J_INV_BACK]   = st_reg.phase == PH_INV && st_reg.d_exoff_on &&
                        !st_reg.s2.inverter &&
                        st_reg.d_exoff >= INV_BACK_MM; // RULE12
    // Registration windows retire once the sheet has left both registration and entrance
    if (!st_reg.s2.registration && !st_reg.s2.entrance)
      st_next.d_reg_on = 1'b0;

    // Phase sequencing; commands acted on only when not jammed
    // Priority: feed-in, speed-up, feed-out, invert
    // Feed-in clears all drives so a stale gate never lingers
    case (st_reg.phase)
      PH_IDLE, PH_FEED, PH_OUT, PH_INV: begin
        if (cmd.feed_in) begin
          // New sheet: feed and belt on, entrance timer starts
          st_next.phase          = PH_FEED;
          st_next.duplex         = cmd.duplex;
          st_next.drv            = '0;
          st_next.drv.feed_motor = 1'b1;
          st_next.drv.belt_motor = 1'b1;
          st_next.t_entry_on     = 1'b1;
          st_next.t_entry        = '0;
        end else if (cmd.speed_up) begin
          // Faster feed opens the registration clear window
          st_next.drv.feed_fast  = 1'b1;
          st_next.t_reg_on       = 1'b1;
          st_next.t_reg          = '0;
        end else if (cmd.feed_out) begin
          st_next.phase          = PH_OUT;
          st_next.drv.feed_motor = 1'b0;
          st_next.drv.feed_fast  = 1'b0;
          st_next.drv.belt_motor = 1'b1;
          st_next.drv.out_motor  = 1'b1;
          st_next.drv.out_slow   = 1'b0;
          // Duplex opens exit gate; simplex keeps it shut
          st_next.drv.exit_gate  = st_reg.duplex; // RULE1 RULE14
          st_next.drv.inv_gate   = 1'b0; // RULE1
          // Reach window counts from the feed-out command
          st_next.d_out_on       = 1'b1;
          st_next.d_out          = '0;
        end else if (cmd.invert) begin
          // Both gates open to steer the sheet into the inverter
          st_next.phase          = PH_INV;
          st_next.drv.belt_motor = 1'b1;
          st_next.drv.out_motor  = 1'b1;
          st_next.drv.exit_gate  = 1'b1;
          st_next.drv.inv_gate   = 1'b1;
          st_next.d_out_on       = 1'b1;
          st_next.d_out          = '0;
        end
      end
      PH_JAM: begin
        // Held until the controller clears it
        // Other commands are ignored so a jam is never driven past
        if (cmd.clear) begin
          st_next.phase = PH_IDLE;
          st_next.flags = '0;
        end
      end
      // Illegal codes fall back to idle
      default: st_next.phase = PH_IDLE;
    endcase

    // Any jam latches its flag and drops every drive
    // A new hit beats a clear in the same cycle: set wins
    // Windows close, though a new registration rise still reopens d_reg while jammed
    if (|hit) begin
      st_next.flags      = st_reg.flags | hit; // RULE16
      st_next.phase      = PH_JAM;
      st_next.drv        = '0; // RULE16
      st_next.t_entry_on = 1'b0;
      st_next.t_reg_on   = 1'b0;
      st_next.d_reg_on   = 1'b0;
      st_next.d_out_on   = 1'b0;
      st_next.d_exit_on  = 1'b0;
      st_next.d_exoff_on = 1'b0;
      st_next.d_slow_on  = 1'b0;
    end
  end

  // State register; synchronous reset to idle, all drives off
  // Phase set apart since zero is not a legal one-hot code
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.phase <= PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs from state flops; jam decoded from phase, scaling a constant
  // Encoder scaling is exported for the controller's use
  assign drive       = st_reg.drv;
  assign jam_flags   = st_reg.flags;
  assign jam         = st_reg.phase == PH_JAM;
  assign orig_len_mm = st_reg.len;
  assign pulses_per_mm_unused = PULSES_PER_MM;

endmodule

// ### testbench/feeder_jam_monitor_props.sv
// Port-level assertions for the feeder transport supervisor
`timescale 1ns/1ps
module feeder_jam_monitor_props
  import feeder_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire sensors_t         sensors_raw,
  input wire cmd_t             cmd,
  input wire logic [7:0]       pulses_per_mm_unused,
  input wire drive_t           drive,
  input wire logic [JAM_W-1:0] jam_flags,
  input wire logic             jam,
  input wire logic [15:0]      orig_len_mm
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reset must leave every output but the encoder scaling quiet
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
    drive == '0 && jam_flags == '0 && !jam && orig_len_mm == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_jam_halts: assert property (jam |-> drive == '0)
    else $error("drive active during jam");
  chk_flag_match: assert property ((jam_flags != '0) == jam)
    else $error("jam level and flags disagree");
  // Flags are sticky until a clear is taken
  chk_flags_hold: assert property (jam && !cmd.clear |=> jam &&
    (jam_flags & $past(jam_flags)) == $past(jam_flags))
    else $error("jam flag lost without clear");
  chk_clear_drops: assert property (jam && cmd.clear |=> !jam)
    else $error("clear not taken");
  chk_out_drive: assert property (!jam && cmd.feed_out &&
    !cmd.feed_in && !cmd.speed_up |=> jam ||
    (drive.belt_motor && drive.out_motor && !drive.inv_gate))
    else $error("feed-out drive wrong");
  chk_inv_drive: assert property (!jam && cmd.invert &&
    !cmd.feed_in && !cmd.speed_up && !cmd.feed_out |=> jam ||
    (drive.exit_gate && drive.inv_gate && drive.belt_motor))
    else $error("invert drive wrong");
  chk_gate_pair: assert property (drive.inv_gate |-> drive.exit_gate)
    else $error("inverter gate without exit gate");
  // Duplex exit: belt must stop shortly after the exit sensor clears
  chk_belt_stop: assert property (drive.exit_gate &&
    !drive.inv_gate && drive.belt_motor && $fell(sensors_raw.exit_s)
    |-> ##[1:5] (!drive.belt_motor || jam))
    else $error("belt kept running after exit tail");
  chk_slow_cause: assert property ($rose(drive.out_slow) |->
    drive.exit_gate && !drive.inv_gate && !sensors_raw.inverter)
    else $error("slow-down outside duplex exit");
  chk_ppm_const: assert property (pulses_per_mm_unused == PULSES_PER_MM)
    else $error("pulses per mm changed");
endmodule

bind feeder_jam_monitor feeder_jam_monitor_props i_props (
  .core_clk(core_clk), .rst(rst), .sensors_raw(sensors_raw), .cmd(cmd),
  .pulses_per_mm_unused(pulses_per_mm_unused), .drive(drive),
  .jam_flags(jam_flags), .jam(jam), .orig_len_mm(orig_len_mm));

// ### testbench/feeder_mech.sv
// Behavioural feeder mechanics: paper sensors and transport encoder
`timescale 1ns/1ps
module feeder_mech
  import feeder_pkg::*;
(
  input  wire logic       core_clk,
  input  wire drive_t     drive,
  input  wire logic [3:0] paper,
  output sensors_t        sensors_raw
);
  logic [1:0] enc_reg = 2'h0; // Encoder phase, one pulse per 4 cycles
  // Encoder stands still unless a transport motor turns
  always @(posedge core_clk) begin
    if (drive.feed_motor | drive.belt_motor | drive.out_motor)
      enc_reg <= enc_reg + 2'h1;
  end
  // Paper levels: entrance, registration, exit, inverter
  assign sensors_raw = {paper, enc_reg[1]};
endmodule

// ### testbench/feeder_jam_monitor_tb.sv
// Self-checking bench for the feeder transport supervisor
`timescale 1ns/1ps
module feeder_jam_monitor_tb;
  import feeder_pkg::*;
  logic             core_clk;
  logic             rst;
  cmd_t             cmd;
  logic [3:0]       paper;     // Entrance, registration, exit, inverter
  sensors_t         sens;
  drive_t           drive;
  logic [JAM_W-1:0] jam_flags;
  logic             jam;
  logic [15:0]      len;
  int               fails;
  int               samples_checked;
  int               seed = 11;
  int               l;         // Random original length in mm
  logic [33:0]      exp_q[$];  // Expected flag words, one per case
  feeder_mech i_feeder_mech (.core_clk(core_clk), .drive(drive),
    .paper(paper), .sensors_raw(sens));
  feeder_jam_monitor i_feeder_jam_monitor (.core_clk(core_clk), .rst(rst),
    .sensors_raw(sens), .cmd(cmd), .pulses_per_mm_unused(),
    .drive(drive), .jam_flags(jam_flags), .jam(jam), .orig_len_mm(len));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Compare and count
  task check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge core_clk);
    #1;
  endtask
  // One-cycle command, then an idle cycle so pulses never merge
  task pulse(input logic [5:0] c);
    cmd = c;
    step;
    cmd = '0;
    step;
  endtask
  // Travel measured on the encoder, as the design does
  task wait_mm(input int n);
    repeat (n * 4) @(posedge sens.encoder);
    #1;
  endtask
  // Feed one original of n mm through entrance and registration
  task feed_len(input logic d, input int n);
    pulse({1'b1, 3'h0, d, 1'b0});
    check(drive.feed_motor & drive.belt_motor, 1'b1);
    paper = 4'hC;
    wait_mm(n);
    paper = 4'h4;
    wait_mm(2);
    check(len == n || len == n - 1, 1'b1);
    pulse(6'h10);
    check(drive.feed_fast, 1'b1);
    paper = 4'h0;
  endtask
  // Command, sensor steps 2 mm apart, then a jam expected lim mm later
  task jam_case(input logic [5:0] c, input logic [15:0] seq,
                input int lim, input int b);
    logic started;
    started = 1'b0;
    exp_q.push_back(34'h1 << b);
    pulse(c);
    if (c == 6'h08)
      check(drive[4:0], 5'h18);
    if (c == 6'h04)
      check(drive[4:0], 5'h1B);
    for (int k = 12; k >= 0; k -= 4) begin
      if (seq[k +: 4] != 4'hF) begin
        if (started)
          wait_mm(2);
        paper = seq[k +: 4];
        started = 1'b1;
      end
    end
    wait_mm(lim - 2);
    check(jam, 1'b0);
    for (int i = 0; i < 100 && jam !== 1'b1; i++)
      @(posedge core_clk);
    #1;
    check(jam_flags, exp_q.pop_front());
    check(drive, '0);
    paper = 4'h0;
    pulse(6'h01);
    check({jam, jam_flags}, '0);
    $display("jam case %0d done", b);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog: run needs some 40k cycles, limit kept under 100k
  initial begin
    #(5 * 90000);
    fails++;
    conclude;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    cmd = '0;
    paper = 4'h0;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({drive, jam_flags, jam, len}, '0);
    l = 80 + ($unsigned($random(seed)) % 21);
    feed_len(1'b0, l);
    jam_case(6'h08, 16'hFFF0, 129, J_EXIT_LATE);
    feed_len(1'b0, l);
    jam_case(6'h08, 16'hFFF2, l * 13 / 10, J_EXIT_DWELL);
    feed_len(1'b1, l);
    jam_case(6'h04, 16'hFFF0, 198, J_INV_EXIT_LATE);
    feed_len(1'b1, l);
    jam_case(6'h04, 16'hFFF2, 96, J_INV_REACH);
    feed_len(1'b1, l);
    jam_case(6'h04, 16'hFF23, l * 13 / 10 - 2, J_INV_DWELL);
    feed_len(1'b1, l);
    jam_case(6'h04, 16'h2320, 96, J_INV_BACK);
    jam_case(6'h20, 16'hFFF4, 751, J_REG_TAIL);
    jam_case(6'h20, 16'hFFFC, 442, J_ENTRY_TAIL);
    // Duplex exit to the upper tray
    feed_len(1'b1, l);
    pulse(6'h08);
    check(drive[4:0], 5'h1A);
    paper = 4'h2;
    wait_mm(5);
    paper = 4'h3;
    wait_mm(5);
    paper = 4'h1;
    wait_mm(1);
    check(drive[4:3], 2'b01);
    wait_mm(5);
    paper = 4'h0;
    wait_mm(8);
    check(drive.out_slow, 1'b0);
    wait_mm(4);
    check(drive.out_slow, 1'b1);
    $display("duplex exit done");
    conclude;
  end
endmodule
